// File: pkg/see_defs.svh
`ifndef SEE_DEFS_SVH
`define SEE_DEFS_SVH

// Clock and timing
`define SEE_CLK_MHZ 125
`define SEE_DESEL_NS 250
`define SEE_DESEL_CYC ((`SEE_DESEL_NS * `SEE_CLK_MHZ + 999) / 1000)
`define SEE_TWC_NS 6000000
`define SEE_TEC_NS 6000000
`define SEE_TWL_NS 15000000
`define SEE_TWC_CYC ((`SEE_TWC_NS * `SEE_CLK_MHZ) / 1000)
`define SEE_TEC_CYC ((`SEE_TEC_NS * `SEE_CLK_MHZ) / 1000)
`define SEE_TWL_CYC ((`SEE_TWL_NS * `SEE_CLK_MHZ) / 1000)

// Opcodes and special sub-codes
`define SEE_OPC_READ 2'h2
`define SEE_OPC_WRITE 2'h1
`define SEE_OPC_ERASE 2'h3
`define SEE_OPC_SPECIAL 2'h0
`define SEE_SUB_ERASE_ALL 2'h2
`define SEE_SUB_WRITE_ALL 2'h1
`define SEE_SUB_DISABLE 2'h0
`define SEE_SUB_ENABLE 2'h3

// Opcode plus address bits, data bits
`define SEE_OPA_BITS_X8 5'h0B
`define SEE_OPA_BITS_X16 5'h0A
`define SEE_DBITS_X8 5'h08
`define SEE_DBITS_X16 5'h10

// Width variants
`define SEE_VAR_SELECT 2'h0
`define SEE_VAR_BYTE 2'h1
`define SEE_VAR_WORD 2'h2

// Array
`define SEE_WORDS 128
`define SEE_ERASED 16'hFFFF
`define SEE_MASK_HI 16'hFF00
`define SEE_MASK_LO 16'h00FF
`define SEE_CNT_W 24

`endif

// File: pkg/see_pkg.sv
package see_pkg;

    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_ADDR = 4'h2,
        ST_DATA = 4'h4,
        ST_READ = 4'h8
    } see_state_e;

    typedef enum logic [1:0] {
        OP_ERASE = 2'h0,
        OP_WRITE = 2'h1,
        OP_ERASE_ALL = 2'h2,
        OP_WRITE_ALL = 2'h3
    } see_op_e;

    typedef struct packed {
        logic valid;
        see_op_e op;
        logic [7:0] addr;
        logic [15:0] data;
        logic byte_mode;
    } see_prog_s;

endpackage : see_pkg

// File: hw/see_array.sv
`include "see_defs.svh"

module see_array #(
    parameter int WORDS = `SEE_WORDS,
    parameter int unsigned TWC_CYC = `SEE_TWC_CYC,
    parameter int unsigned TEC_CYC = `SEE_TEC_CYC,
    parameter int unsigned TWL_CYC = `SEE_TWL_CYC
) (
    input wire logic i_clk,
    input wire logic i_reset,
    input see_pkg::see_prog_s i_req,
    input wire logic [$clog2(WORDS)-1:0] i_rd_word,
    output logic [15:0] o_rd_word,
    output logic o_busy
);
    localparam int AW = $clog2(WORDS);

    logic [15:0] mem [WORDS];
    logic [`SEE_CNT_W-1:0] cnt_r;
    see_pkg::see_prog_s job_r;
    logic fin;
    logic all_op;
    logic [15:0] val;
    logic [15:0] mask;

    assign o_rd_word = mem[i_rd_word];
    assign fin = o_busy && (cnt_r == `SEE_CNT_W'(1));
    assign all_op = (job_r.op == see_pkg::OP_ERASE_ALL) || (job_r.op == see_pkg::OP_WRITE_ALL);

    // Runs on the system clock alone, so no serial edges are needed
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            o_busy <= 1'b0;
            cnt_r <= '0;
        end else if (!o_busy && i_req.valid) begin
            o_busy <= 1'b1;
            case (i_req.op)
                see_pkg::OP_ERASE_ALL: cnt_r <= `SEE_CNT_W'(TEC_CYC);
                see_pkg::OP_WRITE_ALL: cnt_r <= `SEE_CNT_W'(TWL_CYC);
                default: cnt_r <= `SEE_CNT_W'(TWC_CYC);
            endcase
        end else if (o_busy) begin
            cnt_r <= cnt_r - `SEE_CNT_W'(1);
            if (fin) begin
                o_busy <= 1'b0;
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            job_r <= '0;
        end else if (!o_busy && i_req.valid) begin
            job_r <= i_req;
        end
    end

    // Writes replace the old contents, which is the built-in erase
    always_comb begin
        val = `SEE_ERASED;
        if (job_r.op == see_pkg::OP_WRITE || job_r.op == see_pkg::OP_WRITE_ALL) begin
            val = job_r.byte_mode ? {2{job_r.data[7:0]}} : job_r.data;
        end
        mask = `SEE_ERASED;
        if (job_r.byte_mode && !all_op) begin
            mask = job_r.addr[0] ? `SEE_MASK_LO : `SEE_MASK_HI;
        end
    end

    // Array contents are nonvolatile, so reset leaves them alone
    for (genvar i = 0; i < WORDS; i++) begin : g_word
        always_ff @(posedge i_clk) begin
            if (fin && (all_op || job_r.addr[AW:1] == AW'(i))) begin
                mem[i] <= (mem[i] & ~mask) | (val & mask);
            end
        end
    end

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_reset);

    erase_all_ones_a: assert property (
        fin && job_r.op == see_pkg::OP_ERASE_ALL |=> mem[0] == `SEE_ERASED
            && mem[WORDS-1] == `SEE_ERASED)
        else $error("erase-all left a word not all ones");

    self_timed_a: assert property (
        o_busy && !fin |=> o_busy && cnt_r == $past(cnt_r) - `SEE_CNT_W'(1))
        else $error("program timer stalled");

endmodule : see_array

// File: hw/see_eeprom.sv
`include "see_defs.svh"

// Notes on behaviour
// - Erase-all sets every array bit to one
// - Erase-all self-timed, starts at select fall
// - Status shown after long deselect during programming
// - Start bit then deselect clears status
// - Power-up with programming disabled
// - Enable holds until disable or power loss
// - Reads work regardless of enable latch
// - Read gives dummy zero then word, MSB first
// - Read bits change on serial clock rise
// - Continued clocking streams following words
// - Write takes word, programs at select fall
// - Status low while busy, high when ready
// - Write-all fills array, needs enable
// - Program cycle needs no serial clocks
// - Deselect is standby; running cycle completes
// - Deselect holds control logic in reset
// - Input bits sampled on serial clock rise
// - Serial clock may pause at either level
// - No start bit: clocks are ignored
// - After full instruction, ignore until start
// - Held deselected: no status, later ready
// - Width pin picks word size unless fixed
// - Start is first rise with select, data high
// - Opcode and special sub-code decoding
// - Single erase sets addressed word to ones
// - Output floats except read data or status
module see_eeprom #(
    parameter logic [1:0] VARIANT = `SEE_VAR_SELECT,
    parameter bit FAST_PROG = 1'b0,
    parameter int unsigned TWC_CYC = `SEE_TWC_CYC,
    parameter int unsigned TEC_CYC = `SEE_TEC_CYC,
    parameter int unsigned TWL_CYC = `SEE_TWL_CYC
) (
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic i_cs,
    input wire logic i_sclk,
    input wire logic i_serial_data_in,
    input wire logic i_word_width_select,
    output logic o_serial_data_out,
    output logic o_serial_data_out_oe
);
    see_pkg::see_state_e state_r;
    see_pkg::see_op_e op_r;
    see_pkg::see_prog_s job;
    see_pkg::see_prog_s pend_r;
    see_pkg::see_prog_s prog_req;
    logic sclk_q_r;
    logic cs_q_r;
    logic sclk_rise;
    logic cs_fall;
    logic x16;
    logic [9:0] sh_r;
    logic [10:0] v;
    logic [4:0] bcnt_r;
    logic [4:0] dbits;
    logic last_opa;
    logic last_dat;
    logic [1:0] opc;
    logic [1:0] sub;
    logic [7:0] baddr;
    logic [15:0] dat_r;
    logic en_latch_r;
    logic armed_r;
    logic clr_req_r;
    logic [5:0] csl_cnt_r;
    logic csl_ok_r;
    logic [7:0] addr_r;
    logic [15:0] rd_sr_r;
    logic [4:0] rcnt_r;
    logic [15:0] rd_word;
    logic [15:0] word16;
    logic busy;
    logic start;
    logic opa_done;
    logic rd_go;
    logic show_stat;

    // Pins are synchronous, so a one-flop delay gives the edges
    // Reset tracks the pins, so a clock left high shows no false rise
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            sclk_q_r <= i_sclk;
            cs_q_r <= i_cs;
        end else begin
            sclk_q_r <= i_sclk;
            cs_q_r <= i_cs;
        end
    end

    assign sclk_rise = i_sclk && !sclk_q_r;
    assign cs_fall = cs_q_r && !i_cs;

    assign x16 = (VARIANT == `SEE_VAR_WORD) ||
        ((VARIANT == `SEE_VAR_SELECT) && i_word_width_select);
    assign dbits = x16 ? `SEE_DBITS_X16 : `SEE_DBITS_X8;
    assign v = {sh_r, i_serial_data_in};
    assign last_opa = (bcnt_r + 5'h01) == (x16 ? `SEE_OPA_BITS_X16 : `SEE_OPA_BITS_X8);
    assign last_dat = (bcnt_r + 5'h01) == dbits;
    assign opc = x16 ? v[9:8] : v[10:9];
    assign sub = x16 ? v[7:6] : v[8:7];
    assign baddr = x16 ? {v[6:0], 1'b0} : v[7:0];

    // Busy or pending program cycles hold off new instructions
    assign start = (state_r == see_pkg::ST_IDLE) && i_cs && sclk_rise && i_serial_data_in
        && !busy && !pend_r.valid;
    assign opa_done = (state_r == see_pkg::ST_ADDR) && i_cs && sclk_rise && last_opa;
    assign rd_go = opa_done && (opc == `SEE_OPC_READ);

    always_ff @(posedge i_clk) begin
        if (i_reset || !i_cs) begin
            state_r <= see_pkg::ST_IDLE;
            bcnt_r <= 5'h00;
        end else begin
            case (state_r)
                see_pkg::ST_IDLE: begin
                    if (start) begin
                        state_r <= see_pkg::ST_ADDR;
                        bcnt_r <= 5'h00;
                    end
                end
                see_pkg::ST_ADDR: begin
                    if (sclk_rise) begin
                        bcnt_r <= bcnt_r + 5'h01;
                        if (last_opa) begin
                            bcnt_r <= 5'h00;
                            if (opc == `SEE_OPC_READ) begin
                                state_r <= see_pkg::ST_READ;
                            end else if (opc == `SEE_OPC_WRITE || (opc == `SEE_OPC_SPECIAL
                                    && sub == `SEE_SUB_WRITE_ALL)) begin
                                state_r <= see_pkg::ST_DATA;
                            end else begin
                                state_r <= see_pkg::ST_IDLE;
                            end
                        end
                    end
                end
                see_pkg::ST_DATA: begin
                    if (sclk_rise) begin
                        bcnt_r <= bcnt_r + 5'h01;
                        if (last_dat) begin
                            state_r <= see_pkg::ST_IDLE;
                        end
                    end
                end
                see_pkg::ST_READ: state_r <= see_pkg::ST_READ;
                default: state_r <= see_pkg::ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            sh_r <= '0;
            dat_r <= '0;
            op_r <= see_pkg::OP_WRITE;
        end else if (start) begin
            sh_r <= '0;
            dat_r <= '0;
        end else if (sclk_rise && state_r == see_pkg::ST_ADDR) begin
            sh_r <= v[9:0];
            op_r <= (opc == `SEE_OPC_WRITE) ? see_pkg::OP_WRITE : see_pkg::OP_WRITE_ALL;
        end else if (sclk_rise && state_r == see_pkg::ST_DATA) begin
            dat_r <= {dat_r[14:0], i_serial_data_in};
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            en_latch_r <= 1'b0;
        end else if (opa_done && opc == `SEE_OPC_SPECIAL) begin
            if (sub == `SEE_SUB_ENABLE) begin
                en_latch_r <= 1'b1;
            end else if (sub == `SEE_SUB_DISABLE) begin
                en_latch_r <= 1'b0;
            end
        end
    end

    // Completed programming instruction; only the latch lets it through
    always_comb begin
        job = '0;
        job.byte_mode = !x16;
        if (opa_done && (opc == `SEE_OPC_ERASE ||
                (opc == `SEE_OPC_SPECIAL && sub == `SEE_SUB_ERASE_ALL))) begin
            job.valid = en_latch_r;
            job.op = (opc == `SEE_OPC_ERASE) ? see_pkg::OP_ERASE : see_pkg::OP_ERASE_ALL;
            job.addr = baddr;
        end else if (state_r == see_pkg::ST_DATA && i_cs && sclk_rise && last_dat) begin
            job.valid = en_latch_r;
            job.op = op_r;
            job.addr = addr_r;
            job.data = {dat_r[14:0], i_serial_data_in};
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            pend_r <= '0;
        end else if (!FAST_PROG && job.valid) begin
            pend_r <= job;
        end else if (cs_fall) begin
            pend_r <= '0;
        end
    end

    // Slow parts launch on select fall, fast parts on the last bit
    assign prog_req = FAST_PROG ? job : (cs_fall ? pend_r : '0);

    see_array #(
        .WORDS(`SEE_WORDS),
        .TWC_CYC(TWC_CYC),
        .TEC_CYC(TEC_CYC),
        .TWL_CYC(TWL_CYC)
    ) u_array (
        .i_clk(i_clk),
        .i_reset(i_reset),
        .i_req(prog_req),
        .i_rd_word(addr_r[7:1]),
        .o_rd_word(rd_word),
        .o_busy(busy)
    );

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            armed_r <= 1'b0;
        end else if (prog_req.valid) begin
            armed_r <= 1'b1;
        end else if (cs_fall && clr_req_r) begin
            armed_r <= 1'b0;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_reset || cs_fall) begin
            clr_req_r <= 1'b0;
        end else if (armed_r && !busy && i_cs && sclk_rise && i_serial_data_in
                && state_r == see_pkg::ST_IDLE) begin
            clr_req_r <= 1'b1;
        end
    end

    // Status is only offered after a full deselect period
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            csl_cnt_r <= 6'h00;
            csl_ok_r <= 1'b0;
        end else if (cs_fall) begin
            csl_cnt_r <= 6'h00;
            csl_ok_r <= 1'b0;
        end else if (!i_cs && csl_cnt_r != 6'(`SEE_DESEL_CYC)) begin
            csl_cnt_r <= csl_cnt_r + 6'h01;
        end else if (!i_cs) begin
            csl_ok_r <= 1'b1;
        end
    end

    assign show_stat = i_cs && armed_r && csl_ok_r && state_r != see_pkg::ST_READ;

    // In byte mode A0 low picks the upper half of the stored word
    assign word16 = x16 ? rd_word : (addr_r[0] ? {rd_word[7:0], 8'h00} : {rd_word[15:8], 8'h00});

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            addr_r <= 8'h00;
        end else if (opa_done) begin
            addr_r <= baddr;
        end else if (state_r == see_pkg::ST_READ && i_cs && sclk_rise && rcnt_r == 5'h01) begin
            addr_r <= addr_r + (x16 ? 8'h02 : 8'h01);
        end
    end

    // A zero count means the next edge loads a fresh word
    always_ff @(posedge i_clk) begin
        if (i_reset || rd_go) begin
            rcnt_r <= 5'h00;
            rd_sr_r <= 16'h0000;
        end else if (state_r == see_pkg::ST_READ && i_cs && sclk_rise) begin
            if (rcnt_r == 5'h00) begin
                rd_sr_r <= {word16[14:0], 1'b0};
                rcnt_r <= dbits - 5'h01;
            end else begin
                rd_sr_r <= {rd_sr_r[14:0], 1'b0};
                rcnt_r <= rcnt_r - 5'h01;
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            o_serial_data_out <= 1'b0;
        end else if (rd_go) begin
            o_serial_data_out <= 1'b0;
        end else if (state_r == see_pkg::ST_READ && i_cs && sclk_rise) begin
            o_serial_data_out <= (rcnt_r == 5'h00) ? word16[15] : rd_sr_r[15];
        end else if (show_stat) begin
            o_serial_data_out <= !busy;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            o_serial_data_out_oe <= 1'b0;
        end else begin
            o_serial_data_out_oe <= i_cs && (rd_go || state_r == see_pkg::ST_READ
                || show_stat);
        end
    end

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_reset);

    sequence s_read_decode;
        rd_go;
    endsequence

    sequence s_prog_launch;
        !FAST_PROG && pend_r.valid && cs_fall && !busy;
    endsequence

    hiz_deselect_a: assert property (!i_cs |=> !o_serial_data_out_oe)
        else $error("data out driven while deselected");

    ctrl_reset_cs_a: assert property (!i_cs |=> state_r == see_pkg::ST_IDLE)
        else $error("control logic active while deselected");

    start_wait_a: assert property (
        state_r == see_pkg::ST_IDLE && i_cs && sclk_rise && !i_serial_data_in
            |=> state_r == see_pkg::ST_IDLE)
        else $error("left idle without a start bit");

    start_detect_a: assert property (start |=> state_r == see_pkg::ST_ADDR)
        else $error("start bit not taken");

    dummy_zero_a: assert property (
        s_read_decode |=> o_serial_data_out_oe && !o_serial_data_out)
        else $error("missing dummy zero before read data");

    read_edge_only_a: assert property (
        state_r == see_pkg::ST_READ && i_cs && !sclk_rise ##1 i_cs
            |-> $stable(o_serial_data_out))
        else $error("read bit changed without a clock rise");

    seq_advance_a: assert property (
        state_r == see_pkg::ST_READ && i_cs && sclk_rise && rcnt_r == 5'h01
            |=> addr_r == $past(addr_r) + (x16 ? 8'h02 : 8'h01))
        else $error("sequential read did not advance");

    launch_gate_a: assert property (prog_req.valid |-> en_latch_r)
        else $error("programming started while disabled");

    launch_fall_a: assert property (s_prog_launch |=> busy ##1 busy)
        else $error("program cycle did not start at select fall");

    status_value_a: assert property (
        show_stat && !rd_go |=> o_serial_data_out_oe && o_serial_data_out == !$past(busy))
        else $error("status does not match busy state");

endmodule : see_eeprom

// File: dv/see_host.sv
module see_host (
    input wire logic i_clk,
    input wire logic i_serial_data_out,
    output logic o_cs,
    output logic o_sclk,
    output logic o_serial_data_in
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        o_cs = 1'h0;
        o_sclk = 1'h0;
        o_serial_data_in = 1'h0;
    end

    // Two or more system clocks per serial phase, so every rise is seen
    task automatic bit_io(input logic b, output logic q);
        @(posedge i_clk);
        o_sclk <= 1'h0;
        o_serial_data_in <= b;
        repeat (2) @(posedge i_clk);
        @(negedge i_clk);
        q = i_serial_data_out;
        @(posedge i_clk);
        o_sclk <= 1'h1;
        @(posedge i_clk);
    endtask : bit_io

    task automatic xfer(input logic [31:0] v, input int n, output logic [31:0] got);
        logic q;
        got = 32'h0;
        for (int i = n - 1; i >= 0; i--) begin
            bit_io(v[i], q);
            got = {got[30:0], q};
        end
    endtask : xfer

    // Data low while select rises; idle clocks with data low come first
    task automatic select(input int idle);
        logic q;
        @(posedge i_clk);
        o_cs <= 1'h1;
        o_serial_data_in <= 1'h0;
        repeat (idle) bit_io(1'h0, q);
    endtask : select

    // Released data line shows the inverse of its last value, never a kind stale level
    task automatic deselect();
        @(posedge i_clk);
        o_cs <= 1'h0;
        o_serial_data_in <= ~o_serial_data_in;
        repeat (40) @(posedge i_clk);
    endtask : deselect
endmodule : see_host

// File: dv/test_serial_eeprom_command_logic.sv
`include "see_defs.svh"

module test_serial_eeprom_command_logic;
    timeunit 1ns;
    timeprecision 1ps;

    logic clk, reset, cs, sclk, sdin, wsel, sdout, oe, en;
    int errors = 0;
    int checks_done = 0;
    int seed = 32'h0CFE1AB3;
    logic [15:0] mem [128];

    see_eeprom #(.VARIANT(`SEE_VAR_SELECT), .FAST_PROG(1'h0), .TWC_CYC(200), .TEC_CYC(200),
        .TWL_CYC(400)) dut (.i_clk(clk), .i_reset(reset), .i_cs(cs), .i_sclk(sclk),
        .i_serial_data_in(sdin), .i_word_width_select(wsel), .o_serial_data_out(sdout),
        .o_serial_data_out_oe(oe));
    see_host host (.i_clk(clk), .i_serial_data_out(sdout), .o_cs(cs), .o_sclk(sclk),
        .o_serial_data_in(sdin));

    initial begin
        clk = 1'h0;
        forever #4 clk = ~clk;
    end

    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        checks_done++;
        if (got !== exp) begin
            $display("unexpected %s expected %h seen %h", what, exp, got);
            errors++;
        end
    endtask : check

    task automatic stop_test();
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : stop_test

    initial begin
        // Roughly three times the longest expected run
        repeat (60000) @(posedge clk);
        errors++;
        $display("watchdog expired");
        stop_test();
    end

    function automatic logic [8:0] fld(logic [1:0] op, logic [1:0] sub, logic [7:0] a, logic w);
        if (op != `SEE_OPC_SPECIAL) return w ? {2'h0, a[6:0]} : {1'h0, a};
        return w ? {1'h0, sub, 6'h0} : {sub, 7'h0};
    endfunction : fld

    function automatic logic [15:0] exp_rd(logic [7:0] a, logic w);
        logic [15:0] m;
        m = mem[w ? a[6:0] : a[7:1]];
        if (w) return m;
        return {8'h00, a[0] ? m[7:0] : m[15:8]};
    endfunction : exp_rd

    // Byte mode: even byte address is the upper half of the stored word
    function automatic void model(logic [1:0] op, logic [1:0] sub, logic [7:0] a,
        logic [15:0] d, logic w);
        logic [15:0] v;
        if (!en) return;
        if (op == `SEE_OPC_SPECIAL) begin
            v = (sub == `SEE_SUB_ERASE_ALL) ? 16'hFFFF : (w ? d : {d[7:0], d[7:0]});
            foreach (mem[i]) mem[i] = v;
            return;
        end
        v = (op == `SEE_OPC_ERASE) ? 16'hFFFF : d;
        if (w) mem[a[6:0]] = v;
        else if (a[0]) mem[a[7:1]][7:0] = v[7:0];
        else mem[a[7:1]][15:8] = v[7:0];
    endfunction : model

    task automatic head(input logic [1:0] op, input logic [8:0] f, input logic w);
        logic [31:0] got;
        @(posedge clk);
        wsel <= w;
        host.select({$random(seed)} % 4);
        if (w) host.xfer({21'h0, 1'h1, op, f[7:0]}, 11, got);
        else host.xfer({20'h0, 1'h1, op, f}, 12, got);
    endtask : head

    task automatic status(input logic busy);
        logic q;
        int k;
        host.select(0);
        repeat (4) @(negedge clk);
        check("status drive", 16'h0001, {15'h0, oe});
        if (busy) check("busy level", 16'h0000, {15'h0, sdout});
        for (k = 0; k < 1000 && sdout !== 1'h1; k++) @(negedge clk);
        check("ready level", 16'h0001, {15'h0, sdout});
        host.bit_io(1'h1, q);
        host.deselect();
        // Reselect after a long low: a status left armed would drive again
        host.select(0);
        repeat (4) @(negedge clk);
        check("status cleared", 16'h0000, {15'h0, oe});
        host.deselect();
    endtask : status

    task automatic prog(input logic [1:0] op, input logic [1:0] sub, input logic [7:0] a,
        input logic [15:0] d, input logic w, input bit cut, input bit poll);
        logic [31:0] got;
        bit dat;
        int dn;
        dat = op == `SEE_OPC_WRITE || (op == `SEE_OPC_SPECIAL && sub == `SEE_SUB_WRITE_ALL);
        dn = w ? 16 : 8;
        head(op, fld(op, sub, a, w), w);
        if (dat) host.xfer({16'h0, d}, cut ? dn - 3 : dn, got);
        host.deselect();
        if (cut && dat) return;
        if (op == `SEE_OPC_SPECIAL && sub == `SEE_SUB_ENABLE) en = 1'h1;
        else if (op == `SEE_OPC_SPECIAL && sub == `SEE_SUB_DISABLE) en = 1'h0;
        else begin
            if (poll && en) status(1'h1);
            model(op, sub, a, d, w);
        end
    endtask : prog

    task automatic rd(input logic [7:0] a, input logic w, input int nw);
        logic [31:0] got;
        head(`SEE_OPC_READ, fld(`SEE_OPC_READ, 2'h0, a, w), w);
        host.xfer(32'h0, 1, got);
        check("dummy bit", 16'h0000, got[15:0]);
        for (int k = 0; k < nw; k++) begin
            host.xfer(32'h0, w ? 16 : 8, got);
            check("read word", exp_rd(a, w), got[15:0]);
            a = w ? {1'h0, a[6:0] + 7'h01} : a + 8'h01;
        end
        host.deselect();
        check("read release", 16'h0000, {15'h0, oe});
    endtask : rd

    task automatic rnd_op();
        logic [31:0] r;
        r = $random(seed);
        case (r[3:1])
            3'h0, 3'h1: prog(`SEE_OPC_WRITE, 2'h0, r[15:8], r[31:16], r[0], r[4] & r[5], 1'h1);
            3'h2: prog(`SEE_OPC_ERASE, 2'h0, r[15:8], 16'h0, r[0], 1'h0, 1'h1);
            3'h3: prog(`SEE_OPC_SPECIAL, `SEE_SUB_WRITE_ALL, 8'h0, r[31:16], r[0], 1'h0, 1'h1);
            default: rd(r[15:8], r[0], 1 + int'(r[5:4]));
        endcase
    endtask : rnd_op

    initial begin
        reset = 1'h1;
        wsel = 1'h1;
        en = 1'h0;
        repeat (12) @(posedge clk);
        reset <= 1'h0;
        @(negedge clk);
        check("idle release", 16'h0000, {15'h0, oe});
        // Array has no reset value, so clear it before any comparison
        prog(`SEE_OPC_SPECIAL, `SEE_SUB_ENABLE, 8'h0, 16'h0, 1'h1, 1'h0, 1'h0);
        prog(`SEE_OPC_SPECIAL, `SEE_SUB_ERASE_ALL, 8'h0, 16'h0, 1'h1, 1'h0, 1'h1);
        rd(8'h7E, 1'h1, 3);
        rd(8'hFF, 1'h0, 2);
        $display("test erase_all done");
        prog(`SEE_OPC_WRITE, 2'h0, 8'h21, 16'hA5C3, 1'h1, 1'h0, 1'h0);
        repeat (600) @(negedge clk);
        check("quiet output", 16'h0000, {15'h0, oe});
        status(1'h0);
        $display("test held_low done");
        prog(`SEE_OPC_SPECIAL, `SEE_SUB_DISABLE, 8'h0, 16'h0, 1'h0, 1'h0, 1'h0);
        prog(`SEE_OPC_WRITE, 2'h0, 8'h21, 16'h1234, 1'h1, 1'h0, 1'h1);
        prog(`SEE_OPC_ERASE, 2'h0, 8'h42, 16'h0, 1'h0, 1'h0, 1'h1);
        prog(`SEE_OPC_SPECIAL, `SEE_SUB_WRITE_ALL, 8'h0, 16'h0F0F, 1'h0, 1'h0, 1'h1);
        prog(`SEE_OPC_SPECIAL, `SEE_SUB_ERASE_ALL, 8'h0, 16'h0, 1'h1, 1'h0, 1'h1);
        rd(8'h20, 1'h1, 2);
        rd(8'h42, 1'h0, 2);
        $display("test disabled done");
        prog(`SEE_OPC_SPECIAL, `SEE_SUB_ENABLE, 8'h0, 16'h0, 1'h0, 1'h0, 1'h0);
        repeat (40) rnd_op();
        prog(`SEE_OPC_WRITE, 2'h0, 8'h10, 16'h5A5A, 1'h1, 1'h1, 1'h1);
        rd(8'h10, 1'h1, 1);
        $display("test random done");
        @(posedge clk);
        reset <= 1'h1;
        repeat (2) @(posedge clk);
        reset <= 1'h0;
        en = 1'h0;
        prog(`SEE_OPC_WRITE, 2'h0, 8'h10, 16'h0000, 1'h1, 1'h0, 1'h1);
        rd(8'h10, 1'h1, 1);
        $display("test reset done");
        stop_test();
    end
endmodule : test_serial_eeprom_command_logic
